/* hdl/branch_call_return_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module branch_call_return_unit (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // instruction request from decoder
  input wire logic i_start,
  input wire bcr_pkg::op_t i_op,
  input wire logic i_trap,
  input wire logic [23:0] i_operand,
  input wire logic [7:0] i_accumulator,
  input wire logic [15:0] i_data_pointer,
  input wire logic [7:0] i_extended_status_word,
  // static configuration
  input wire logic i_source_mode,
  input wire logic i_interrupt_frame_size_select,
  input wire logic i_internal_exec,
  // stack interface: one byte per beat
  output logic o_push,
  output logic o_pop,
  output logic [7:0] o_stack_wdata,
  input wire logic [7:0] i_stack_rdata,
  // results
  output logic [23:0] o_pc,
  output logic [7:0] o_extended_status_word,
  output logic o_status_load,
  output logic o_busy,
  output logic o_done
);
  typedef enum {S_IDLE, S_PUSH, S_POP, S_WAIT} fsm_t;

  bcr_timer_if tif();
  bcr_state_timer u_timer (.i_clock(i_clock), .i_rst_n(i_rst_n), .t(tif));

  fsm_t st_r, st_nxt;
  logic [23:0] pc_r, pc_nxt;
  logic [23:0] tgt_r, tgt_nxt;
  logic [31:0] sbuf_r, sbuf_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] esw_r, esw_nxt;
  logic esw_ld_r, esw_ld_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic push_r, push_nxt, pop_r, pop_nxt;
  logic pop_pc_r, pop_pc_nxt;
  // a popped byte is valid the cycle after the pop pulse, so capture runs one cycle behind it
  logic rcv_r, rcv_nxt;
  logic [2:0] rx_r, rx_nxt;
  logic start_t;
  logic [4:0] states_t;

  // combinational decode of the accepted request
  logic [23:0] adv, target;
  logic [2:0] len;
  logic [4:0] base;
  logic is_jump, is_call, is_ret, is_abs;
  logic [2:0] npush, npop;
  logic [31:0] frame;

  always_comb begin
    len = 3'd1;
    base = 5'd1;
    target = pc_r;
    is_jump = 1'b0;
    is_call = 1'b0;
    is_ret = 1'b0;
    is_abs = 1'b0;
    npush = 3'd0;
    npop = 3'd0;
    if (i_trap) begin
      len = 3'd1;
      base = 5'd9;
      is_call = 1'b1;
    end else begin
      unique case (i_op)
        bcr_pkg::OP_NO_OPERATION: begin
          len = 3'd1;
          base = 5'd1;
        end
        bcr_pkg::OP_ABSOLUTE_JUMP: begin
          len = 3'd2;
          base = 5'd3;
          is_jump = 1'b1;
          is_abs = 1'b1;
        end
        bcr_pkg::OP_EXTENDED_JUMP: begin
          len = i_source_mode ? 3'd4 : 3'd5;
          base = i_source_mode ? 5'd5 : 5'd6;
          is_jump = 1'b1;
        end
        bcr_pkg::OP_EXTENDED_JUMP_IND: begin
          len = i_source_mode ? 3'd2 : 3'd3;
          base = i_source_mode ? 5'd6 : 5'd7;
          is_jump = 1'b1;
        end
        bcr_pkg::OP_LONG_JUMP: begin
          len = 3'd3;
          base = 5'd5;
          is_jump = 1'b1;
        end
        bcr_pkg::OP_LONG_JUMP_IND: begin
          len = i_source_mode ? 3'd2 : 3'd3;
          base = i_source_mode ? 5'd5 : 5'd6;
          is_jump = 1'b1;
        end
        bcr_pkg::OP_SHORT_RELATIVE_JUMP: begin
          len = 3'd2;
          base = 5'd4;
          is_jump = 1'b1;
        end
        bcr_pkg::OP_INDIRECT_JUMP: begin
          len = 3'd1;
          base = 5'd5;
          is_jump = 1'b1;
        end
        bcr_pkg::OP_ABSOLUTE_CALL: begin
          len = 3'd2;
          base = 5'd9;
          is_call = 1'b1;
          is_abs = 1'b1;
        end
        bcr_pkg::OP_EXTENDED_CALL: begin
          len = i_source_mode ? 3'd4 : 3'd5;
          base = i_source_mode ? 5'd13 : 5'd14;
          is_call = 1'b1;
        end
        bcr_pkg::OP_EXTENDED_CALL_IND: begin
          len = i_source_mode ? 3'd2 : 3'd3;
          base = i_source_mode ? 5'd13 : 5'd14;
          is_call = 1'b1;
        end
        bcr_pkg::OP_LONG_CALL: begin
          len = 3'd3;
          base = 5'd9;
          is_call = 1'b1;
        end
        bcr_pkg::OP_LONG_CALL_IND: begin
          len = i_source_mode ? 3'd2 : 3'd3;
          base = i_source_mode ? 5'd9 : 5'd10;
          is_call = 1'b1;
        end
        bcr_pkg::OP_SUBROUTINE_EXIT,
        bcr_pkg::OP_EXTENDED_SUBROUTINE_EXIT: begin
          base = 5'd7;
          is_ret = 1'b1;
        end
        bcr_pkg::OP_INTERRUPT_EXIT: begin
          base = 5'd9;
          is_ret = 1'b1;
        end
      endcase
    end
    adv = pc_r + {21'h000000, len};
    frame = {8'h00, adv};
    if (i_trap) begin
      npush = i_interrupt_frame_size_select ? 3'd4 : 3'd2;
      frame = i_interrupt_frame_size_select ? {adv, i_extended_status_word} : {16'h0000, adv[15:0]};
      target = i_operand;
    end else begin
      unique case (i_op)
        bcr_pkg::OP_ABSOLUTE_JUMP, bcr_pkg::OP_ABSOLUTE_CALL: begin
          target = {adv[23:11], i_operand[10:0]};
        end
        bcr_pkg::OP_EXTENDED_JUMP, bcr_pkg::OP_EXTENDED_JUMP_IND: begin
          target = i_operand;
        end
        bcr_pkg::OP_LONG_JUMP, bcr_pkg::OP_LONG_JUMP_IND: begin
          target = {adv[23:16], i_operand[15:0]};
        end
        bcr_pkg::OP_SHORT_RELATIVE_JUMP: begin
          target = adv + {{16{i_operand[7]}}, i_operand[7:0]};
        end
        bcr_pkg::OP_INDIRECT_JUMP: begin
          target = {bcr_pkg::INDIRECT_PAGE, {8'h00, i_accumulator} + i_data_pointer};
        end
        bcr_pkg::OP_EXTENDED_CALL, bcr_pkg::OP_EXTENDED_CALL_IND: begin
          target = i_operand;
          npush = 3'd3;
        end
        bcr_pkg::OP_LONG_CALL, bcr_pkg::OP_LONG_CALL_IND: begin
          target = {adv[23:16], i_operand[15:0]};
          npush = 3'd2;
        end
        bcr_pkg::OP_SUBROUTINE_EXIT: begin
          npop = 3'd2;
        end
        bcr_pkg::OP_EXTENDED_SUBROUTINE_EXIT: begin
          npop = 3'd3;
        end
        bcr_pkg::OP_INTERRUPT_EXIT: begin
          npop = i_interrupt_frame_size_select ? 3'd4 : 3'd2;
        end
        default: begin
          target = adv;
        end
      endcase
      if (is_abs && npush == 3'd0 && is_call) begin
        npush = 3'd2;
      end
    end
  end

  // extra states known at issue; returns get no odd penalty
  logic tgt_ext, tgt_odd;
  logic [4:0] extra;
  always_comb begin
    tgt_ext = target[23:16] != bcr_pkg::INTERNAL_PAGE;
    tgt_odd = i_internal_exec && !tgt_ext && target[0];
    extra = 5'd0;
    if (is_jump || is_call) begin
      if (tgt_odd) begin
        extra = extra + bcr_pkg::ADD_ODD;
      end
      if (tgt_ext) begin
        extra = extra + ((is_abs || is_call) ? bcr_pkg::ADD_EXT_SHORT : bcr_pkg::ADD_EXT_LONG);
      end
    end
    if ((i_trap || i_op == bcr_pkg::OP_INTERRUPT_EXIT) && i_interrupt_frame_size_select) begin
      extra = extra + bcr_pkg::ADD_FRAME4;
    end
  end

  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    tgt_nxt = tgt_r;
    sbuf_nxt = sbuf_r;
    cnt_nxt = cnt_r;
    esw_nxt = esw_r;
    esw_ld_nxt = 1'b0;
    wd_nxt = wd_r;
    push_nxt = 1'b0;
    pop_nxt = 1'b0;
    pop_pc_nxt = pop_pc_r;
    rcv_nxt = pop_r;
    rx_nxt = rx_r;
    start_t = 1'b0;
    states_t = base + extra;
    unique case (st_r)
      S_IDLE: begin
        if (i_start && !tif.busy) begin
          start_t = 1'b1;
          tgt_nxt = (is_ret) ? pc_r : target;
          sbuf_nxt = frame;
          cnt_nxt = npush | npop;
          rx_nxt = 3'd0;
          if (npush != 3'd0) begin
            st_nxt = S_PUSH;
          end else if (npop != 3'd0) begin
            st_nxt = S_POP;
            // three or more pops restore all 24 pc bits
            pop_pc_nxt = npop >= 3'd3;
          end else begin
            st_nxt = S_WAIT;
          end
        end
      end
      S_PUSH: begin
        // status word first for a four-byte trap frame, then pc low byte first
        push_nxt = 1'b1;
        wd_nxt = sbuf_r[7:0];
        sbuf_nxt = {8'h00, sbuf_r[31:8]};
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd1) begin
          st_nxt = S_WAIT;
        end
      end
      S_POP: begin
        // one pop pulse per byte; bytes are taken in below
        pop_nxt = 1'b1;
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd1) begin
          st_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (tif.done) begin
          pc_nxt = tgt_r;
          st_nxt = S_IDLE;
        end
      end
    endcase
    // high byte comes off first; a fourth byte is the status word
    if (rcv_r) begin
      rx_nxt = rx_r + 3'd1;
      if (rx_r == 3'd3) begin
        esw_nxt = i_stack_rdata;
        esw_ld_nxt = 1'b1;
      end else if (pop_pc_r) begin
        tgt_nxt = {tgt_r[15:0], i_stack_rdata};
      end else begin
        // two-byte return keeps the current page
        tgt_nxt = {tgt_r[23:16], tgt_r[7:0], i_stack_rdata};
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_r <= S_IDLE;
      pc_r <= '0;
      tgt_r <= '0;
      sbuf_r <= '0;
      cnt_r <= '0;
      esw_r <= '0;
      esw_ld_r <= 1'b0;
      wd_r <= '0;
      push_r <= 1'b0;
      pop_r <= 1'b0;
      pop_pc_r <= 1'b0;
      rcv_r <= 1'b0;
      rx_r <= '0;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      tgt_r <= tgt_nxt;
      sbuf_r <= sbuf_nxt;
      cnt_r <= cnt_nxt;
      esw_r <= esw_nxt;
      esw_ld_r <= esw_ld_nxt;
      wd_r <= wd_nxt;
      push_r <= push_nxt;
      pop_r <= pop_nxt;
      pop_pc_r <= pop_pc_nxt;
      rcv_r <= rcv_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign tif.start = start_t;
  assign tif.states = states_t;
  assign o_push = push_r;
  assign o_pop = pop_r;
  assign o_stack_wdata = wd_r;
  assign o_pc = pc_r;
  assign o_extended_status_word = esw_r;
  assign o_status_load = esw_ld_r;
  assign o_busy = st_r != S_IDLE;
  assign o_done = st_r == S_WAIT && tif.done;

  a_nop_advance: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op == bcr_pkg::OP_NO_OPERATION
    |-> ##2 o_done ##1 o_pc == $past(o_pc, 3) + 24'h000001)
    else $error("no operation timing or advance wrong");
  a_ind_page: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op == bcr_pkg::OP_INDIRECT_JUMP && !tgt_odd && !tgt_ext
    |-> ##10 o_done ##1 o_pc[23:16] == 8'hff)
    else $error("indirect jump page wrong");
  a_short_relative_jump_states: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op == bcr_pkg::OP_SHORT_RELATIVE_JUMP && !tgt_odd && !tgt_ext
    |-> !o_done [*8] ##1 o_done)
    else $error("short jump state count wrong");
  a_long_jump_keep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op == bcr_pkg::OP_LONG_JUMP
    |=> tgt_r[15:0] == $past(i_operand[15:0]))
    else $error("long jump target wrong");
  a_absolute_jump_upper: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op == bcr_pkg::OP_ABSOLUTE_JUMP
    |=> tgt_r[10:0] == $past(i_operand[10:0]) && tgt_r[23:11] == $past(adv[23:11]))
    else $error("absolute jump target wrong");
  a_extended_jump_full: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op == bcr_pkg::OP_EXTENDED_JUMP |=> tgt_r == $past(i_operand))
    else $error("extended jump target wrong");
  a_long_call_push: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op inside {bcr_pkg::OP_LONG_CALL, bcr_pkg::OP_LONG_CALL_IND}
    |-> ##2 o_push ##1 o_push ##1 !o_push)
    else $error("long call push count wrong");
  a_extended_call_push: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && !i_trap && i_op inside {bcr_pkg::OP_EXTENDED_CALL, bcr_pkg::OP_EXTENDED_CALL_IND}
    |-> ##2 o_push [*3] ##1 !o_push)
    else $error("extended call push count wrong");
  a_frame_extra: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_r == S_IDLE && i_start && i_trap |-> states_t >= (i_interrupt_frame_size_select ? 5'd14 : 5'd9))
    else $error("trap frame states wrong");
endmodule : branch_call_return_unit
`default_nettype wire

/* hdl/bcr_pkg.sv */
package bcr_pkg;

  // operation codes presented by the decoder
  typedef enum logic [3:0] {
    OP_NO_OPERATION,
    OP_ABSOLUTE_JUMP,
    OP_EXTENDED_JUMP,
    OP_EXTENDED_JUMP_IND,
    OP_LONG_JUMP,
    OP_LONG_JUMP_IND,
    OP_SHORT_RELATIVE_JUMP,
    OP_INDIRECT_JUMP,
    OP_ABSOLUTE_CALL,
    OP_EXTENDED_CALL,
    OP_EXTENDED_CALL_IND,
    OP_LONG_CALL,
    OP_LONG_CALL_IND,
    OP_SUBROUTINE_EXIT,
    OP_EXTENDED_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT
  } op_t;

  localparam int PC_W = 24;
  localparam int STATE_W = 5;
  localparam logic [7:0] INDIRECT_PAGE = 8'hff;
  localparam int CLOCKS_PER_STATE = 2;
  localparam logic [STATE_W-1:0] ADD_ODD = 5'h01;
  localparam logic [STATE_W-1:0] ADD_EXT_SHORT = 5'h02;
  localparam logic [STATE_W-1:0] ADD_EXT_LONG = 5'h03;
  localparam logic [STATE_W-1:0] ADD_FRAME4 = 5'h05;
  localparam logic [7:0] INTERNAL_PAGE = 8'hff;

endpackage : bcr_pkg

/* hdl/bcr_timer_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface bcr_timer_if;
  logic start;
  logic [bcr_pkg::STATE_W-1:0] states;
  logic busy;
  logic done;
  modport ctrl (output start, output states, input busy, input done);
  modport timer (input start, input states, output busy, output done);
endinterface : bcr_timer_if
`default_nettype wire

/* hdl/bcr_state_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// counts instruction states, each two system clocks long
module bcr_state_timer (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // control
  bcr_timer_if.timer t
);
  logic [bcr_pkg::STATE_W-1:0] left_r, left_nxt;
  logic phase_r, phase_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    left_nxt = left_r;
    phase_nxt = phase_r;
    busy_nxt = busy_r;
    if (t.start && !busy_r) begin
      busy_nxt = 1'b1;
      left_nxt = t.states;
      phase_nxt = 1'b0;
    end else if (busy_r) begin
      phase_nxt = ~phase_r;
      if (phase_r) begin
        left_nxt = left_r - 5'h01;
        if (left_r == 5'h01) begin
          busy_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      left_r <= '0;
      phase_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      left_r <= left_nxt;
      phase_r <= phase_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign t.busy = busy_r;
  assign t.done = busy_r && phase_r && left_r == 5'h01;

  a_state_two_clk: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    busy_r && !phase_r |=> phase_r && busy_r)
    else $error("state shorter than two clocks");
endmodule : bcr_state_timer
`default_nettype wire

/* tb/branch_call_return_unit_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module branch_call_return_unit_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  bcr_pkg::op_t op = bcr_pkg::OP_NO_OPERATION;
  logic trap = 1'b0;
  logic [23:0] operand = 24'h000000;
  logic [7:0] accumulator = 8'h00;
  logic [15:0] data_pointer = 16'h0000;
  logic [7:0] status_in = 8'h00;
  logic source_mode = 1'b0;
  logic frame_sel = 1'b0;
  logic internal_exec = 1'b1;
  logic [7:0] stack_rdata = 8'h5a;
  logic push;
  logic pop;
  logic status_load;
  logic busy;
  logic done;
  logic [7:0] stack_wdata;
  logic [7:0] status_out;
  logic [23:0] pc;
  logic [7:0] push_q[$];
  logic [7:0] pop_q[$];
  int loads = 0;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  always #10 clock = ~clock;

  branch_call_return_unit branch_call_return_unit_i (
    .i_clock(clock), .i_rst_n(rst_n), .i_start(start), .i_op(op), .i_trap(trap),
    .i_operand(operand), .i_accumulator(accumulator), .i_data_pointer(data_pointer),
    .i_extended_status_word(status_in), .i_source_mode(source_mode),
    .i_interrupt_frame_size_select(frame_sel), .i_internal_exec(internal_exec),
    .o_push(push), .o_pop(pop), .o_stack_wdata(stack_wdata), .i_stack_rdata(stack_rdata),
    .o_pc(pc), .o_extended_status_word(status_out), .o_status_load(status_load),
    .o_busy(busy), .o_done(done)
  );

  // stack side: popped bytes appear the cycle after the pop pulse, otherwise the lines
  // toggle so that a stale byte can never be read as a good one
  always @(posedge clock) begin
    if (push) begin
      push_q.push_back(stack_wdata);
    end
    if (status_load) begin
      loads++;
    end
    if (pop && pop_q.size() > 0) begin
      stack_rdata <= pop_q.pop_front();
    end else begin
      stack_rdata <= ~stack_rdata;
    end
  end

  task automatic compare(input logic [23:0] got, input logic [23:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : compare

  task automatic results;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic set_cfg(input logic src, input logic frame, input logic internal);
    @(posedge clock);
    source_mode <= src;
    frame_sel <= frame;
    internal_exec <= internal;
  endtask : set_cfg

  // one request; poke raises start again while busy, which must be ignored
  task automatic run_op(input bcr_pkg::op_t code, input logic is_trap, input logic [23:0] value,
                        input logic poke = 1'b0);
    @(posedge clock);
    start <= 1'b1;
    op <= code;
    trap <= is_trap;
    operand <= value;
    @(posedge clock);
    start <= 1'b0;
    // the taken edge counts as the first cycle
    cycles = 1;
    do begin
      @(posedge clock);
      start <= poke && cycles == 3;
      #1;
      cycles++;
    end while (done !== 1'b1 && cycles < 200);
    if (done !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: no completion pulse", $time);
      results();
    end
    @(posedge clock);
    #1;
  endtask : run_op

  task automatic check_states(input int n);
    compare(24'(cycles), 24'(bcr_pkg::CLOCKS_PER_STATE * n), "cycle count");
  endtask : check_states

  task automatic check_stack(input int n, input logic [31:0] bytes);
    compare(24'(push_q.size()), 24'(n), "pushed byte count");
    for (int i = 0; i < n && i < push_q.size(); i++) begin
      compare({16'h0000, push_q[i]}, {16'h0000, bytes[8*i+:8]}, "pushed byte");
    end
    push_q.delete();
  endtask : check_stack

  task automatic s_reset;
    compare(pc, 24'h000000, "pc after reset");
    compare({23'h000000, busy}, 24'h000000, "busy after reset");
    $display("test reset finished");
  endtask : s_reset

  task automatic s_no_operation;
    run_op(bcr_pkg::OP_NO_OPERATION, 1'b0, 24'h000000);
    compare(pc, 24'h000001, "pc after no operation");
    check_states(1);
    $display("test no operation finished");
  endtask : s_no_operation

  task automatic s_external_jumps;
    // upper operand bits are junk and must not reach the pc
    run_op(bcr_pkg::OP_LONG_JUMP, 1'b0, 24'hab1234);
    compare(pc, 24'h001234, "pc after long jump");
    check_states(8);
    run_op(bcr_pkg::OP_ABSOLUTE_JUMP, 1'b0, 24'h000246);
    compare(pc, 24'h001246, "pc after absolute jump");
    check_states(5);
    $display("test external jumps finished");
  endtask : s_external_jumps

  task automatic s_indirect_jump;
    accumulator <= 8'h12;
    data_pointer <= 16'hfff0;
    run_op(bcr_pkg::OP_INDIRECT_JUMP, 1'b0, 24'h000000);
    compare(pc, 24'hff0002, "pc after indirect jump");
    check_states(5);
    $display("test indirect jump finished");
  endtask : s_indirect_jump

  task automatic s_internal_jumps;
    run_op(bcr_pkg::OP_EXTENDED_JUMP, 1'b0, 24'hff0101);
    compare(pc, 24'hff0101, "pc after extended jump");
    check_states(7);
    set_cfg(1'b1, 1'b0, 1'b1);
    run_op(bcr_pkg::OP_EXTENDED_JUMP, 1'b0, 24'hff0203);
    compare(pc, 24'hff0203, "pc after extended jump");
    check_states(6);
    set_cfg(1'b0, 1'b0, 1'b0);
    run_op(bcr_pkg::OP_EXTENDED_JUMP, 1'b0, 24'hff0305);
    check_states(6);
    set_cfg(1'b0, 1'b0, 1'b1);
    run_op(bcr_pkg::OP_ABSOLUTE_JUMP, 1'b0, 24'h000246);
    compare(pc, 24'hff0246, "pc after absolute jump");
    check_states(3);
    run_op(bcr_pkg::OP_SHORT_RELATIVE_JUMP, 1'b0, 24'h0000fc);
    compare(pc, 24'hff0244, "pc after short jump");
    check_states(4);
    $display("test internal jumps finished");
  endtask : s_internal_jumps

  task automatic s_calls;
    run_op(bcr_pkg::OP_LONG_CALL_IND, 1'b0, 24'h003000);
    compare(pc, 24'hff3000, "pc after long call");
    check_stack(2, 32'h00000247);
    check_states(10);
    set_cfg(1'b1, 1'b0, 1'b1);
    run_op(bcr_pkg::OP_LONG_CALL_IND, 1'b0, 24'h003001);
    check_stack(2, 32'h00003002);
    check_states(10);
    set_cfg(1'b0, 1'b0, 1'b1);
    run_op(bcr_pkg::OP_EXTENDED_CALL_IND, 1'b0, 24'h012345);
    compare(pc, 24'h012345, "pc after extended call");
    check_stack(3, 32'h00ff3004);
    check_states(16);
    set_cfg(1'b1, 1'b0, 1'b1);
    run_op(bcr_pkg::OP_EXTENDED_CALL_IND, 1'b0, 24'hff0010);
    check_stack(3, 32'h00012347);
    check_states(13);
    $display("test calls finished");
  endtask : s_calls

  task automatic s_trap;
    set_cfg(1'b0, 1'b1, 1'b1);
    status_in <= 8'hc3;
    run_op(bcr_pkg::OP_NO_OPERATION, 1'b1, 24'hff0400, 1'b1);
    compare(pc, 24'hff0400, "pc after trap");
    check_stack(4, 32'hff0011c3);
    check_states(14);
    set_cfg(1'b0, 1'b0, 1'b1);
    run_op(bcr_pkg::OP_NO_OPERATION, 1'b1, 24'hff0500);
    check_stack(2, 32'h00000401);
    check_states(9);
    $display("test trap finished");
  endtask : s_trap

  task automatic s_interrupt_exit;
    int four_cycles;
    set_cfg(1'b0, 1'b1, 1'b1);
    pop_q = '{8'hff, 8'h04, 8'h02, 8'ha5};
    loads = 0;
    run_op(bcr_pkg::OP_INTERRUPT_EXIT, 1'b0, 24'h000000);
    four_cycles = cycles;
    compare(pc, 24'hff0402, "pc after four byte exit");
    compare({16'h0000, status_out}, 24'h0000a5, "status word");
    compare(24'(loads), 24'h000001, "status loads");
    set_cfg(1'b0, 1'b0, 1'b1);
    pop_q = '{8'h12, 8'h34};
    loads = 0;
    run_op(bcr_pkg::OP_INTERRUPT_EXIT, 1'b0, 24'h000000);
    compare(pc, 24'hff1234, "pc after two byte exit");
    compare(24'(loads), 24'h000000, "status loads");
    compare(24'(pop_q.size()), 24'h000000, "bytes left unpopped");
    compare(24'(four_cycles - cycles), 24'(bcr_pkg::CLOCKS_PER_STATE * 5), "frame penalty");
    $display("test interrupt exit finished");
  endtask : s_interrupt_exit

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    s_reset();
    s_no_operation();
    s_external_jumps();
    s_indirect_jump();
    s_internal_jumps();
    s_calls();
    s_trap();
    s_interrupt_exit();
    results();
  end
endmodule : branch_call_return_unit_tb_top
`default_nettype wire
